// ===== pin_router_pkg.sv
package pin_router_pkg;

   typedef logic [7:0] sfr_byte_t;

   typedef enum logic [1:0] {
      sel_none,
      sel_route0,
      sel_route1,
      sel_route2
   } route_sel_t;

endpackage

// ===== pin_router_regs.svh
`ifndef PIN_ROUTER_REGS_SVH
`define PIN_ROUTER_REGS_SVH

// Register page and special-function addresses.
`define ROUTE_PAGE            8'h0F
`define ROUTE0_ADDR           8'hE1
`define ROUTE1_ADDR           8'hE2
`define ROUTE2_ADDR           8'hE3

// Reset value shared by all three routing registers.
`define ROUTE_RESET           8'h00

// Value read back from an address this block does not own.
`define ROUTE_UNMAPPED        8'h00

// First routing register fields.
`define R0_COMP_A_BIT         7
`define R0_PCA_CLK_BIT        6
`define R0_PCA_CNT_HI         5
`define R0_PCA_CNT_LO         3
`define R0_UART_A_BIT         2
`define R0_SPI_BIT            1
`define R0_SMBUS_BIT          0

// Second routing register fields.
`define R1_CLK_OUT_BIT        7
`define R1_T2_CAP_BIT         6
`define R1_T2_CNT_BIT         5
`define R1_IRQ_B_BIT          4
`define R1_T1_CNT_BIT         3
`define R1_IRQ_A_BIT          2
`define R1_T0_CNT_BIT         1
`define R1_COMP_B_BIT         0

// Third routing register fields.
`define R2_PULLUP_DIS_BIT     7
`define R2_XBAR_EN_BIT        6
`define R2_CONV_B_BIT         5
`define R2_T4_CAP_BIT         4
`define R2_T4_CNT_BIT         3
`define R2_UART_B_BIT         2
`define R2_EMIF_LOW_BIT       1
`define R2_CONV_A_BIT         0

// Largest number of counter-array outputs that can be routed.
`define PCA_OUT_MAX           3'h6

`endif

// ===== pin_side_model.sv
module pin_side_model (
   input  wire logic mclk,
   input  wire logic port_force_input,
   input  wire logic pullup_enable,
   output      logic pin_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toggle_q = 1'b0;
   always @(posedge mclk) toggle_q <= ~toggle_q;
   // A pulled-up input rests high; otherwise the pin toggles on every rising mclk edge.
   assign pin_level = (port_force_input && pullup_enable)
                      ? 1'b1 : toggle_q;
endmodule

// ===== port_pin_crossbar_enables.sv
// Contract
// - Third register bit 7 set turns off all weak pull-ups.
// - With the crossbar enable clear, ports 0 to 3 are forced to input.
// - Bit 6 of the third register enables the crossbar's routing.
// - Bit 5 of the third register routes the second conversion start.
// - Bit 4 of the third register routes the timer 4 capture input.
// - Bit 3 of the third register routes the timer 4 count input.
// - The third register sits at 0xE3 on page F, read/write, reset 0.
// - Bit 2 of the third register routes the second UART to two pins.
// - Bit 1 of the third register makes the crossbar skip strobe pins.
// - Bit 0 of the third register routes the first conversion start.
`include "pin_router_regs.svh"

module port_pin_crossbar_enables (
   input  wire  logic                      mclk,
   input  wire  logic                      rst_b,
   input  wire  logic [7:0]                sfr_addr,
   input  wire  logic [7:0]                sfr_page,
   input  wire  logic                      sfr_wr,
   input  wire  logic                      sfr_rd,
   input  wire  pin_router_pkg::sfr_byte_t sfr_wdata,
   output       pin_router_pkg::sfr_byte_t sfr_rdata,
   output       logic                      sfr_rvalid,
   output       logic                      pullup_enable,
   output       logic                      port_force_input,
   output       logic                      comparator_a_out_route,
   output       logic                      comparator_b_out_route,
   output       logic                      counter_array_clk_in_route,
   output       logic [5:0]                counter_array_out_route,
   output       logic                      first_uart_route,
   output       logic                      spi_route,
   output       logic                      smbus_route,
   output       logic                      clock_out_route,
   output       logic                      timer2_capture_route,
   output       logic                      timer2_count_route,
   output       logic                      ext_irq_b_route,
   output       logic                      timer1_count_route,
   output       logic                      ext_irq_a_route,
   output       logic                      timer0_count_route,
   output       logic                      timer4_count_route,
   output       logic                      timer4_capture_route,
   output       logic                      conv_start_a_route,
   output       logic                      conv_start_b_route,
   output       logic                      second_uart_route,
   output       logic                      ext_mem_low_port_skip
);
   import pin_router_pkg::*;

   sfr_byte_t  route0_q;
   sfr_byte_t  route0_d;
   sfr_byte_t  route1_q;
   sfr_byte_t  route1_d;
   sfr_byte_t  route2_q;
   sfr_byte_t  route2_d;
   sfr_byte_t  rdata_q;
   sfr_byte_t  rdata_d;
   logic       rvalid_q;
   logic       rvalid_d;
   route_sel_t acc_sel;
   logic       xbar_en;
   logic [2:0] pca_count;
   logic [1:0] glob_q;
   logic [1:0] glob_d;
   logic [5:0] pca_q;
   logic [5:0] pca_d;
   logic [4:0] grp0_q;
   logic [4:0] grp0_d;
   sfr_byte_t  grp1_q;
   sfr_byte_t  grp1_d;
   logic [5:0] grp2_q;
   logic [5:0] grp2_d;

   // Maps a page and address pair onto one of the routing registers.
   function automatic route_sel_t decode_sel(input logic [7:0] page,
                                             input logic [7:0] addr);
      route_sel_t sel;
      sel = sel_none;
      if (page == `ROUTE_PAGE) begin
         unique case (addr)
            `ROUTE0_ADDR: sel = sel_route0;
            `ROUTE1_ADDR: sel = sel_route1;
            `ROUTE2_ADDR: sel = sel_route2;
            default:      sel = sel_none;
         endcase
      end
      return sel;
   endfunction

   // Turns the output-count field into one enable per counter-array output.
   function automatic logic [5:0] pca_mask(input logic [2:0] count);
      logic [5:0] mask;
      mask = 6'h00;
      for (int i = 0; i < 6; i++) begin
         if (3'(i) < count) begin
            mask[i] = 1'b1;
         end
      end
      return mask;
   endfunction

   assign acc_sel = decode_sel(sfr_page, sfr_addr);

   // Register writes and read-back capture.
   always_comb begin
      route0_d = route0_q;
      route1_d = route1_q;
      route2_d = route2_q;
      rdata_d  = rdata_q;
      rvalid_d = sfr_rd;
      if (sfr_wr) begin
         unique case (acc_sel)
            sel_route0: route0_d = sfr_wdata;
            sel_route1: route1_d = sfr_wdata;
            sel_route2: route2_d = sfr_wdata;
            sel_none:   route0_d = route0_q;
         endcase
      end
      if (sfr_rd) begin
         unique case (acc_sel)
            sel_route0: rdata_d = route0_q;
            sel_route1: rdata_d = route1_q;
            sel_route2: rdata_d = route2_q;
            sel_none:   rdata_d = `ROUTE_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         route0_q <= `ROUTE_RESET;
         route1_q <= `ROUTE_RESET;
         route2_q <= `ROUTE_RESET;
         rdata_q  <= `ROUTE_UNMAPPED;
         rvalid_q <= 1'b0;
      end else begin
         route0_q <= route0_d;
         route1_q <= route1_d;
         route2_q <= route2_d;
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign sfr_rdata  = rdata_q;
   assign sfr_rvalid = rvalid_q;

   // Routing images are built from the next register values, so each
   // registered output follows a write in the same cycle as its register.
   assign xbar_en   = route2_d[`R2_XBAR_EN_BIT];

   // Counter-array outputs; a field value above six routes all six.
   assign pca_count = (route0_d[`R0_PCA_CNT_HI:`R0_PCA_CNT_LO] > `PCA_OUT_MAX)
                      ? `PCA_OUT_MAX
                      : route0_d[`R0_PCA_CNT_HI:`R0_PCA_CNT_LO];

   // Every routed group is held off while the crossbar is disabled.
   always_comb begin
      glob_d[1] = ~route2_d[`R2_PULLUP_DIS_BIT];
      glob_d[0] = ~xbar_en;
      pca_d     = 6'h00;
      grp0_d    = 5'h00;
      grp1_d    = 8'h00;
      grp2_d    = 6'h00;
      if (xbar_en) begin
         pca_d     = pca_mask(pca_count);
         grp0_d[4] = route0_d[`R0_COMP_A_BIT];
         grp0_d[3] = route0_d[`R0_PCA_CLK_BIT];
         grp0_d[2] = route0_d[`R0_UART_A_BIT];
         grp0_d[1] = route0_d[`R0_SPI_BIT];
         grp0_d[0] = route0_d[`R0_SMBUS_BIT];
         grp1_d    = route1_d;
         grp2_d[`R2_CONV_B_BIT]   = route2_d[`R2_CONV_B_BIT];
         grp2_d[`R2_T4_CAP_BIT]   = route2_d[`R2_T4_CAP_BIT];
         grp2_d[`R2_T4_CNT_BIT]   = route2_d[`R2_T4_CNT_BIT];
         grp2_d[`R2_UART_B_BIT]   = route2_d[`R2_UART_B_BIT];
         grp2_d[`R2_EMIF_LOW_BIT] = route2_d[`R2_EMIF_LOW_BIT];
         grp2_d[`R2_CONV_A_BIT]   = route2_d[`R2_CONV_A_BIT];
      end
   end

   // With every routing bit clear, pull-ups are on and ports are inputs.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         glob_q <= 2'h3;
         pca_q  <= 6'h00;
         grp0_q <= 5'h00;
         grp1_q <= 8'h00;
         grp2_q <= 6'h00;
      end else begin
         glob_q <= glob_d;
         pca_q  <= pca_d;
         grp0_q <= grp0_d;
         grp1_q <= grp1_d;
         grp2_q <= grp2_d;
      end
   end

   // Global controls and counter-array outputs.
   assign pullup_enable              = glob_q[1];
   assign port_force_input           = glob_q[0];
   assign counter_array_out_route    = pca_q;

   // First routing register groups.
   assign comparator_a_out_route     = grp0_q[4];
   assign counter_array_clk_in_route = grp0_q[3];
   assign first_uart_route           = grp0_q[2];
   assign spi_route                  = grp0_q[1];
   assign smbus_route                = grp0_q[0];

   // Second routing register groups.
   assign clock_out_route            = grp1_q[`R1_CLK_OUT_BIT];
   assign timer2_capture_route       = grp1_q[`R1_T2_CAP_BIT];
   assign timer2_count_route         = grp1_q[`R1_T2_CNT_BIT];
   assign ext_irq_b_route            = grp1_q[`R1_IRQ_B_BIT];
   assign timer1_count_route         = grp1_q[`R1_T1_CNT_BIT];
   assign ext_irq_a_route            = grp1_q[`R1_IRQ_A_BIT];
   assign timer0_count_route         = grp1_q[`R1_T0_CNT_BIT];
   assign comparator_b_out_route     = grp1_q[`R1_COMP_B_BIT];

   // Third routing register groups.
   assign conv_start_b_route         = grp2_q[`R2_CONV_B_BIT];
   assign timer4_capture_route       = grp2_q[`R2_T4_CAP_BIT];
   assign timer4_count_route         = grp2_q[`R2_T4_CNT_BIT];
   assign second_uart_route          = grp2_q[`R2_UART_B_BIT];
   assign ext_mem_low_port_skip      = grp2_q[`R2_EMIF_LOW_BIT];
   assign conv_start_a_route         = grp2_q[`R2_CONV_A_BIT];

endmodule

// ===== port_pin_crossbar_enables_bench.sv
`include "pin_router_regs.svh"
module port_pin_crossbar_enables_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pin_router_pkg::*;
   logic mclk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00;
   sfr_byte_t sfr_wdata = 8'h00, sfr_rdata;
   logic sfr_rvalid, pullup_enable, port_force_input, pin_level;
   logic [5:0] counter_array_out_route;
   logic comparator_a_out_route, comparator_b_out_route, spi_route;
   logic counter_array_clk_in_route, first_uart_route, smbus_route;
   logic clock_out_route, timer2_capture_route, timer2_count_route;
   logic ext_irq_b_route, timer1_count_route, ext_irq_a_route;
   logic timer0_count_route, timer4_count_route, timer4_capture_route;
   logic conv_start_a_route, conv_start_b_route, second_uart_route;
   logic ext_mem_low_port_skip;
   int n_errors = 0, checks = 0, k;
   logic [7:0] m [3];
   always #5 mclk = ~mclk;
   port_pin_crossbar_enables dut (.*);
   pin_side_model pins (.*);
   task chk(input logic [7:0] s, input logic [7:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task outs;
      logic e;
      e = m[2][6];
      k = m[0][5:3] > 6 ? 6 : m[0][5:3];
      chk(pullup_enable, !m[2][7]);
      chk(port_force_input, !e);
      chk({comparator_a_out_route, counter_array_clk_in_route,
         first_uart_route, spi_route, smbus_route},
         e ? {m[0][7:6], m[0][2:0]} : 0);
      chk({clock_out_route, timer2_capture_route, timer2_count_route,
         ext_irq_b_route, timer1_count_route, ext_irq_a_route,
         timer0_count_route, comparator_b_out_route},
         e ? m[1] : 0);
      chk({conv_start_b_route, timer4_capture_route, timer4_count_route},
         e ? m[2][5:3] : 0);
      chk({second_uart_route, ext_mem_low_port_skip, conv_start_a_route},
         e ? m[2][2:0] : 0);
      chk(counter_array_out_route, e ? 8'((1 << k) - 1) : 0);
      if (!e && !m[2][7]) chk(pin_level, 1);
   endtask
   task req(input logic w, input logic [7:0] p, a, d);
      logic hit;
      logic [7:0] want;
      hit = p == `ROUTE_PAGE && a >= `ROUTE0_ADDR && a <= `ROUTE2_ADDR;
      want = `ROUTE_UNMAPPED;
      if (hit) want = m[a - `ROUTE0_ADDR];
      @(posedge mclk);
      sfr_wr <= w;
      sfr_rd <= !w;
      sfr_page <= p;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge mclk);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      #1;
      if (w && hit) m[a - `ROUTE0_ADDR] = d;
      chk(sfr_rvalid, !w);
      if (!w) chk(sfr_rdata, want);
      outs;
   endtask
   task pair(input logic [7:0] d);
      @(posedge mclk);
      sfr_page <= `ROUTE_PAGE;
      sfr_addr <= `ROUTE2_ADDR;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      sfr_rd <= 1'b1;
      @(posedge mclk);
      sfr_wr <= 1'b0;
      #1;
      chk(sfr_rdata, m[2]);
      m[2] = d;
      outs;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1;
      chk(sfr_rvalid, 1);
      chk(sfr_rdata, d);
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge mclk);
      n_errors++;
      print_verdict;
   end
   initial begin
      void'($urandom(28));
      m = '{default: `ROUTE_RESET};
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         req(0, `ROUTE_PAGE, 8'(`ROUTE0_ADDR + i), 0);
      end
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         req(1, `ROUTE_PAGE, `ROUTE2_ADDR, 8'h40 | 8'(1 << i));
         req(0, `ROUTE_PAGE, `ROUTE2_ADDR, 0);
         req(1, `ROUTE_PAGE, `ROUTE2_ADDR, 8'(1 << i));
      end
      $display("third register test done");
      req(1, `ROUTE_PAGE, `ROUTE2_ADDR, 8'h40);
      for (int i = 0; i < 8; i++) begin
         req(1, `ROUTE_PAGE, `ROUTE0_ADDR, 8'(i << 3));
      end
      $display("output count test done");
      repeat (60) req(1'($urandom), $urandom % 3 ? `ROUTE_PAGE : 8'($urandom),
         8'hE0 + 8'($urandom % 5), 8'($urandom));
      $display("random test done");
      repeat (4) pair(8'($urandom));
      $display("back to back test done");
      @(posedge mclk);
      rst_b <= 1'b0;
      #1;
      m = '{default: `ROUTE_RESET};
      outs;
      chk(sfr_rvalid, 0);
      chk(sfr_rdata, `ROUTE_RESET);
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         req(0, `ROUTE_PAGE, 8'(`ROUTE0_ADDR + i), 0);
      end
      $display("mid-run reset test done");
      print_verdict;
   end
endmodule

// ===== port_pin_crossbar_enables_chk.sv
module port_pin_crossbar_enables_chk (
   input wire logic                      mclk,
   input wire logic                      rst_b,
   input wire logic [7:0]                sfr_addr,
   input wire logic [7:0]                sfr_page,
   input wire logic                      sfr_wr,
   input wire logic                      sfr_rd,
   input wire pin_router_pkg::sfr_byte_t sfr_wdata,
   input wire pin_router_pkg::sfr_byte_t sfr_rdata,
   input wire logic                      sfr_rvalid,
   input wire logic                      pullup_enable,
   input wire logic                      port_force_input,
   input wire logic [5:0]                counter_array_out_route,
   input wire logic                      spi_route,
   input wire logic                      conv_start_b_route,
   input wire logic                      ext_mem_low_port_skip
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic w2;
   logic r2;
   assign w2 = sfr_wr && sfr_page == 8'h0F && sfr_addr == 8'hE3;
   assign r2 = sfr_rd && !sfr_wr && sfr_page == 8'h0F && sfr_addr == 8'hE3;
   property p_pull;
      w2 |=> pullup_enable == !$past(sfr_wdata[7]);
   endproperty
   a_pull: assert property (p_pull)
      else $error("pull-up state wrong");
   property p_force;
      w2 |=> port_force_input == !$past(sfr_wdata[6]);
   endproperty
   a_force: assert property (p_force)
      else $error("enable wrong");
   property p_gate;
      port_force_input |-> !spi_route && !conv_start_b_route
         && !ext_mem_low_port_skip && counter_array_out_route == 6'h00;
   endproperty
   a_gate: assert property (p_gate)
      else $error("route while off");
   property p_cnvb;
      w2 |=> conv_start_b_route ==
         ($past(sfr_wdata[6]) && $past(sfr_wdata[5]));
   endproperty
   a_cnvb: assert property (p_cnvb)
      else $error("conv b wrong");
   property p_emif;
      w2 |=> ext_mem_low_port_skip ==
         ($past(sfr_wdata[6]) && $past(sfr_wdata[1]));
   endproperty
   a_emif: assert property (p_emif)
      else $error("skip wrong");
   property p_rv;
      sfr_rd |=> sfr_rvalid;
   endproperty
   a_rv: assert property (p_rv)
      else $error("no read answer");
   property p_hold;
      !sfr_rvalid |-> $stable(sfr_rdata);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved");
   property p_back;
      w2 ##1 r2 |=> sfr_rdata == $past(sfr_wdata, 2);
   endproperty
   a_back: assert property (p_back)
      else $error("readback wrong");
   property p_cnt;
      counter_array_out_route inside
         {6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F};
   endproperty
   a_cnt: assert property (p_cnt)
      else $error("output set gap");
endmodule
bind port_pin_crossbar_enables port_pin_crossbar_enables_chk chk_i (.*);
